// ==== inc/line_flags_regs.svh ====
// Register map, field positions, reset values and counts of the line flags
// block. Included by bare name; holds definitions only.
`ifndef LINE_FLAGS_REGS_SVH
`define LINE_FLAGS_REGS_SVH

// Byte addresses on the register bus
`define DATA_OFS          12'h000
`define LINE_STATUS_OFS   12'h004
`define CTRL_OFS          12'h008
`define INT_STATUS_OFS    12'h00C
`define INT_MASK_OFS      12'h010

// Line status field positions
`define LS_RX_READY       0
`define LS_OVERRUN        1
`define LS_PARITY         2
`define LS_FRAMING        3
`define LS_BREAK          4
`define LS_TX_HOLD_EMPTY  5
`define LS_TX_ALL_EMPTY   6
`define LS_FIFO_ERROR     7

// Interrupt status and mask field positions
`define INT_W             3
`define INT_TX_EMPTY      0
`define INT_RX_DATA       1
`define INT_RX_ERROR      2

// Reset values
`define CTRL_RESET        2'h0
`define INT_MASK_RESET    3'h0

// Sizes and counts
`define FIFO_DEPTH        128
`define FRAME_CYCLES      160

`endif

// ==== inc/line_flags_pkg.sv ====
// Types shared by the line flags block and its register-level bench.
// Assumes nothing beyond a SystemVerilog compiler.
package line_flags_pkg;

  // One received character with its error flags
  typedef struct packed {
    logic       brk;
    logic       framing;
    logic       parity;
    logic [7:0] data;
  } rx_entry_t;

  // Control register layout
  typedef struct packed {
    logic tx_empty_ie;
    logic fifo_en;
  } ctrl_t;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

endpackage

// ==== design/flag_fifo_mem.sv ====
// Small two-port memory for the receive and transmit queues.
// Assumes one clock; read data comes from a register and shows the word
// at raddr as of the previous edge, a write to that word included.
`timescale 1ns/10ps
module flag_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_r
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Bypass keeps the head valid one edge after a write into an empty queue
  wire              bypass   = we && (waddr == raddr);
  wire [WIDTH-1:0]  rd_nxt   = bypass ? wdata : mem[raddr];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= rd_nxt;
    end
  end

endmodule

// ==== design/uart_line_status_flags.sv ====
// Line status flags of one UART channel, with receive and transmit queues,
// break detector and an APB register slave.
// Assumes pclk is the UART clock, a serialiser that takes tx_char on
// tx_start and reports tx_shift_done, and a deserialiser that pulses
// rx_char_valid with each finished character.
//
// Overview of operation
// - Bit 7 set when queued character has error
// - Bit 7 clears when no queued errors remain
// - Bit 6 high when holding and shifter empty
// - FIFO mode: bit 6 needs FIFO, shifter empty
// - Bit 5 set when shifter takes the character
// - Bit 5 clears when CPU writes a character
// - Transmit interrupt while bit 5 and enabled
// - FIFO mode: bit 5 tracks transmit FIFO empty
// - Bit 4 set after one frame of low
// - One break character per break condition
// - Bit 3 zero without framing error
// - Bit 3 flags missing stop bit at head
// - Bit 2 flags parity error at head
// - Bit 1 overrun; queue contents kept unchanged
// - Bit 0 set while received data waits
`timescale 1ns/10ps
`include "line_flags_regs.svh"
module uart_line_status_flags #(
  parameter int DEPTH        = `FIFO_DEPTH,
  parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  output logic                        tx_irq,
  input  wire logic                   rx_line,
  input  wire logic                   rx_char_valid,
  input  wire line_flags_pkg::rx_entry_t rx_char,
  input  wire logic                   tx_shift_done,
  output logic                        tx_start,
  output logic      [7:0]             tx_char
);
  import line_flags_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int BW = $clog2(FRAME_CYCLES + 1);
  localparam logic [BW-1:0] BRK_LAST = BW'(FRAME_CYCLES - 1);
  localparam logic [CW-1:0] CAP_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CAP_ONE  = CW'(1);

  function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c,
                                             input logic up,
                                             input logic dn);
    if (up && !dn) begin
      return c + CW'(1);
    end else if (dn && !up) begin
      return c - CW'(1);
    end
    return c;
  endfunction

  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p,
                                             input logic inc);
    return inc ? p + AW'(1) : p;
  endfunction

  // Registers
  ctrl_t             ctrl_r;
  logic [`INT_W-1:0] int_sts_r;
  logic [`INT_W-1:0] int_mask_r;
  logic              overrun_r;
  logic              tx_empty_q_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic              irq_r;
  logic              tx_irq_r;
  logic              tx_start_r;
  logic [7:0]        tx_char_r;
  tx_state_t         tx_state_r;
  logic [CW-1:0]     rx_cnt_r;
  logic [CW-1:0]     tx_cnt_r;
  logic [CW-1:0]     err_cnt_r;
  logic [AW-1:0]     rx_wp_r;
  logic [AW-1:0]     rx_rp_r;
  logic [AW-1:0]     tx_wp_r;
  logic [AW-1:0]     tx_rp_r;
  logic [BW-1:0]     brk_cnt_r;
  logic              brk_done_r;
  rx_entry_t         rx_head;
  logic [7:0]        tx_head;
  logic [7:0]        line_status;

  // Bus decode
  wire setup     = psel && !penable;
  wire done      = psel && penable && pready_r;
  wire wr_en     = done && pwrite;
  wire rd_en     = done && !pwrite;
  wire hit_data  = paddr == `DATA_OFS;
  wire hit_ls    = paddr == `LINE_STATUS_OFS;
  wire hit_ctrl  = paddr == `CTRL_OFS;
  wire hit_ists  = paddr == `INT_STATUS_OFS;
  wire hit_imask = paddr == `INT_MASK_OFS;
  wire mapped    = hit_data | hit_ls | hit_ctrl | hit_ists | hit_imask;

  // Non-FIFO mode is a queue of one: holding register and receive buffer
  wire [CW-1:0] cap    = ctrl_r.fifo_en ? CAP_FULL : CAP_ONE;
  wire rx_nonempty     = rx_cnt_r != '0;
  wire rx_full         = rx_cnt_r >= cap;
  wire tx_full         = tx_cnt_r >= cap;

  // Break detector: one push per low stretch of at least one frame, however long
  wire brk_push = !rx_line && !brk_done_r && (brk_cnt_r == BRK_LAST);
  wire rx_push  = brk_push || rx_char_valid;
  // Break enters the queue as a zero byte carrying the break flag
  wire rx_entry_t rx_in = brk_push ?
      rx_entry_t'{brk: 1'b1, framing: 1'b0, parity: 1'b0, data: 8'h00} :
      rx_entry_t'{brk: 1'b0, framing: rx_char.framing,
                  parity: rx_char.parity, data: rx_char.data};
  wire rx_in_err  = rx_in.brk | rx_in.framing | rx_in.parity;
  wire head_err   = rx_head.brk | rx_head.framing | rx_head.parity;
  wire rx_wr      = rx_push && !rx_full;
  wire overrun_ev = rx_push && rx_full;
  wire rx_pop     = rd_en && hit_data && rx_nonempty;
  wire err_up     = rx_wr && rx_in_err;
  wire err_dn     = rx_pop && head_err;

  // Transmit side
  wire tx_wr      = wr_en && hit_data && !tx_full;
  wire tx_load    = (tx_state_r == TX_IDLE) && (tx_cnt_r != '0);
  wire tx_empty   = tx_cnt_r == '0;
  wire tx_all_mt  = tx_empty && (tx_state_r == TX_IDLE);

  wire [AW-1:0] rx_rp_nxt = ptr_step(rx_rp_r, rx_pop);
  wire [AW-1:0] tx_rp_nxt = ptr_step(tx_rp_r, tx_load);

  // Line status; parity, framing and break are flags of the head character, zero while the queue is empty
  assign line_status[`LS_RX_READY]      = rx_nonempty;
  assign line_status[`LS_OVERRUN]       = overrun_r;
  assign line_status[`LS_PARITY]        = rx_nonempty && rx_head.parity;
  assign line_status[`LS_FRAMING]       = rx_nonempty && rx_head.framing;
  assign line_status[`LS_BREAK]         = rx_nonempty && rx_head.brk;
  assign line_status[`LS_TX_HOLD_EMPTY] = tx_empty;
  assign line_status[`LS_TX_ALL_EMPTY]  = tx_all_mt;
  assign line_status[`LS_FIFO_ERROR]    = err_cnt_r != '0;

  wire [`INT_W-1:0] int_ev;
  assign int_ev[`INT_TX_EMPTY] = tx_empty && !tx_empty_q_r;
  assign int_ev[`INT_RX_DATA]  = rx_wr;
  assign int_ev[`INT_RX_ERROR] = (rx_wr && rx_in_err) || overrun_ev;

  // Set wins over a write-one-to-clear in the same cycle
  wire [`INT_W-1:0] ists_clr = (wr_en && hit_ists) ?
                               pwdata[`INT_W-1:0] : '0;
  wire [`INT_W-1:0] ists_nxt = (int_sts_r & ~ists_clr) | int_ev;

  wire [31:0] rd_mux =
      hit_data  ? {24'h000000, rx_head.data} :
      hit_ls    ? {24'h000000, line_status} :
      hit_ctrl  ? {30'h00000000, ctrl_r} :
      hit_ists  ? {29'h00000000, int_sts_r} :
      hit_imask ? {29'h00000000, int_mask_r} : 32'h00000000;

  // Overrun is cleared by reading line status; a new overrun wins
  wire overrun_nxt = overrun_ev || (overrun_r && !(rd_en && hit_ls));

  flag_fifo_mem #(
    .WIDTH ($bits(rx_entry_t)),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_mem (
    .clk     (pclk),
    .rst_n   (presetn),
    .ce      (ce),
    .we      (rx_wr),
    .waddr   (rx_wp_r),
    .wdata   (rx_in),
    .raddr   (rx_rp_nxt),
    .rdata_r (rx_head)
  );

  flag_fifo_mem #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_tx_mem (
    .clk     (pclk),
    .rst_n   (presetn),
    .ce      (ce),
    .we      (tx_wr),
    .waddr   (tx_wp_r),
    .wdata   (pwdata[7:0]),
    .raddr   (tx_rp_nxt),
    .rdata_r (tx_head)
  );

  // Bus slave: one wait-free access phase, data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else if (ce) begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `CTRL_RESET;
      int_mask_r <= `INT_MASK_RESET;
      int_sts_r  <= '0;
      irq_r      <= 1'b0;
      tx_irq_r   <= 1'b0;
      overrun_r  <= 1'b0;
    end else if (ce) begin
      if (wr_en && hit_ctrl) begin
        ctrl_r <= ctrl_t'(pwdata[1:0]);
      end
      if (wr_en && hit_imask) begin
        int_mask_r <= pwdata[`INT_W-1:0];
      end
      int_sts_r <= ists_nxt;
      irq_r     <= |(ists_nxt & int_mask_r);
      tx_irq_r  <= tx_empty && ctrl_r.tx_empty_ie;
      overrun_r <= overrun_nxt;
    end
  end

  // Receive queue bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_r  <= '0;
      err_cnt_r <= '0;
      rx_wp_r   <= '0;
      rx_rp_r   <= '0;
    end else if (ce) begin
      rx_cnt_r  <= cnt_step(rx_cnt_r, rx_wr, rx_pop);
      err_cnt_r <= cnt_step(err_cnt_r, err_up, err_dn);
      rx_wp_r   <= ptr_step(rx_wp_r, rx_wr);
      rx_rp_r   <= rx_rp_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_cnt_r  <= '0;
      brk_done_r <= 1'b0;
    end else if (ce) begin
      if (rx_line) begin
        brk_cnt_r  <= '0;
        brk_done_r <= 1'b0;
      end else if (brk_push) begin
        brk_cnt_r  <= '0;
        brk_done_r <= 1'b1;
      end else if (!brk_done_r) begin
        brk_cnt_r <= brk_cnt_r + BW'(1);
      end
    end
  end

  // Transmit queue and shifter occupancy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_r     <= '0;
      tx_wp_r      <= '0;
      tx_rp_r      <= '0;
      tx_state_r   <= TX_IDLE;
      tx_start_r   <= 1'b0;
      tx_char_r    <= 8'h00;
      tx_empty_q_r <= 1'b1;
    end else if (ce) begin
      tx_cnt_r     <= cnt_step(tx_cnt_r, tx_wr, tx_load);
      tx_wp_r      <= ptr_step(tx_wp_r, tx_wr);
      tx_rp_r      <= tx_rp_nxt;
      tx_start_r   <= tx_load;
      tx_empty_q_r <= tx_empty;
      if (tx_load) begin
        tx_char_r  <= tx_head;
        tx_state_r <= TX_SHIFT;
      end else if (tx_shift_done) begin
        tx_state_r <= TX_IDLE;
      end
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign irq      = irq_r;
  assign tx_irq   = tx_irq_r;
  assign tx_start = tx_start_r;
  assign tx_char  = tx_char_r;

  a_err_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && err_up |=> line_status[`LS_FIFO_ERROR])
    else $error("error summary not set after errored push");

  a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_nonempty |-> !line_status[`LS_FIFO_ERROR])
    else $error("error summary set with empty receive queue");

  a_temt_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tx_wr |=> !line_status[`LS_TX_ALL_EMPTY])
    else $error("transmit empty still set after write");

  a_temt_shift: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state_r == TX_SHIFT |-> !line_status[`LS_TX_ALL_EMPTY])
    else $error("transmit empty set while shifting");

  a_thre_load: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tx_load && tx_cnt_r == CW'(1) && !tx_wr
      |=> line_status[`LS_TX_HOLD_EMPTY] && tx_start)
    else $error("holding empty not set on load");

  a_thre_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tx_wr |=> !line_status[`LS_TX_HOLD_EMPTY])
    else $error("holding empty not cleared on write");

  a_tx_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> tx_irq == $past(tx_empty && ctrl_r.tx_empty_ie))
    else $error("transmit interrupt does not follow empty flag");

  a_one_break: assert property (@(posedge pclk) disable iff (!presetn)
    ce && brk_push |=> !brk_push [*2])
    else $error("more than one break character pushed");

  a_overrun: assert property (@(posedge pclk) disable iff (!presetn)
    ce && overrun_ev && !rx_pop
      |=> overrun_r && rx_cnt_r == $past(rx_cnt_r))
    else $error("overrun changed queue or was not flagged");

  a_rx_ready: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rx_wr |=> line_status[`LS_RX_READY])
    else $error("receive ready not set after push");

endmodule

// ==== verification/serial_tx_model.sv ====
// Serialiser standing at the far side of the transmit link.
// Assumes tx_start pulses one cycle with tx_char valid beside it.
`timescale 1ns/10ps
module serial_tx_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_char,
  input  wire logic       slow,
  output logic            tx_shift_done,
  output logic [7:0]      last_char,
  output logic [7:0]      sent_count
);
  int unsigned left;

  // A slow shifter keeps the character long enough to read flags meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_done <= 1'b0;
      last_char <= 8'h00;
      sent_count <= 8'h00;
      left <= 0;
    end else begin
      tx_shift_done <= 1'b0;
      if (tx_start) begin
        left <= slow ? 40 : 2;
        last_char <= tx_char;
        sent_count <= sent_count + 8'h01;
      end else if (left == 1) begin
        tx_shift_done <= 1'b1;
        left <= 0;
      end else if (left != 0) begin
        left <= left - 1;
      end
    end
  end
endmodule

// ==== verification/test_uart_line_status_flags.sv ====
// Register-level bench for the line status flags block.
// Assumes the serialiser model above and small queue and frame counts.
`timescale 1ns/10ps
`include "line_flags_regs.svh"
module test_uart_line_status_flags;
  import line_flags_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, irq, tx_irq, rx_line, rx_char_valid;
  rx_entry_t rx_char;
  logic tx_shift_done, tx_start, slow;
  logic [7:0] tx_char, last_char, sent_count;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int checks_done = 0;

  uart_line_status_flags #(.DEPTH(4), .FRAME_CYCLES(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .tx_irq(tx_irq), .rx_line(rx_line), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .tx_shift_done(tx_shift_done),
    .tx_start(tx_start), .tx_char(tx_char));

  serial_tx_model u_ser (
    .pclk(pclk), .presetn(presetn), .tx_start(tx_start),
    .tx_char(tx_char), .slow(slow), .tx_shift_done(tx_shift_done),
    .last_char(last_char), .sent_count(sent_count));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Enter just after a rising edge; returns one edge after the completing
  // edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so the next call never drives psel twice in one step
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check({24'h0, rd[7:0]}, exp);
  endtask

  task automatic rx_push(input logic fr, input logic par,
                         input logic [7:0] d);
    rx_char_valid <= 1'b1;
    rx_char <= {1'b0, fr, par, d};
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char <= ~{1'b0, fr, par, d};
    @(posedge pclk);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (tx_shift_done !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      stop_test();
    end
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_line = 1'b1;
    rx_char_valid = 1'b0;
    rx_char = '0;
    slow = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`LINE_STATUS_OFS, 32'h60);
    rd_chk(`CTRL_OFS, 32'h00);
    rd_chk(`INT_MASK_OFS, 32'h00);
    apb(1'b0, 12'h014, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Non-FIFO transmit with a slow shifter
    apb(1'b1, `CTRL_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    check({31'h0, tx_irq}, 32'h1);
    apb(1'b1, `INT_STATUS_OFS, 32'h7);
    apb(1'b1, `DATA_OFS, 32'hA5);
    repeat (4) @(posedge pclk);
    rd_chk(`LINE_STATUS_OFS, 32'h20);
    check({24'h0, last_char}, 32'hA5);
    wait_done();
    rd_chk(`LINE_STATUS_OFS, 32'h60);
    rd_chk(`INT_STATUS_OFS, 32'h01);
    apb(1'b1, `INT_MASK_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `INT_STATUS_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `INT_MASK_OFS, 32'h0);
    // FIFO transmit, three back-to-back characters
    apb(1'b1, `CTRL_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, tx_irq}, 32'h0);
    apb(1'b1, `DATA_OFS, 32'h11);
    apb(1'b1, `DATA_OFS, 32'h22);
    apb(1'b1, `DATA_OFS, 32'h33);
    rd_chk(`LINE_STATUS_OFS, 32'h00);
    wait_done();
    rd_chk(`LINE_STATUS_OFS, 32'h00);
    wait_done();
    wait_done();
    rd_chk(`LINE_STATUS_OFS, 32'h60);
    check({24'h0, last_char}, 32'h33);
    check({24'h0, sent_count}, 32'h04);
    // Non-FIFO receive: parity error, then overrun
    apb(1'b1, `CTRL_OFS, 32'h0);
    rx_push(1'b0, 1'b1, 8'h3C);
    rx_push(1'b0, 1'b0, 8'h7E);
    rd_chk(`LINE_STATUS_OFS, 32'hE7);
    rd_chk(`DATA_OFS, 32'h3C);
    rd_chk(`LINE_STATUS_OFS, 32'h60);
    // FIFO receive: error hidden behind a clean head
    apb(1'b1, `CTRL_OFS, 32'h1);
    rx_push(1'b0, 1'b0, 8'h5A);
    rx_push(1'b1, 1'b0, 8'hC3);
    rd_chk(`LINE_STATUS_OFS, 32'hE1);
    rd_chk(`DATA_OFS, 32'h5A);
    rd_chk(`LINE_STATUS_OFS, 32'hE9);
    rd_chk(`DATA_OFS, 32'hC3);
    rd_chk(`LINE_STATUS_OFS, 32'h60);
    // Long break gives one zero character
    rx_line <= 1'b0;
    repeat (30) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (2) @(posedge pclk);
    rd_chk(`LINE_STATUS_OFS, 32'hF1);
    rd_chk(`DATA_OFS, 32'h00);
    rd_chk(`LINE_STATUS_OFS, 32'h60);
    rd_chk(`INT_STATUS_OFS, 32'h07);
    stop_test();
  end
endmodule
